// File: csc_pkg.sv
package csc_pkg;
  localparam int CMAX     = 16;
  localparam int COEF_W   = 18;
  localparam int FRAC     = 14;
  localparam int RES_W    = 24;
  localparam int LAT_CORE = 9;
  localparam int NEV      = 6;
  // register byte offsets
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_STAT  = 8'h04;
  localparam logic [7:0] A_MASK  = 8'h08;
  localparam logic [7:0] A_SIZE  = 8'h0C;
  localparam logic [7:0] A_CLIP  = 8'h10;
  localparam logic [7:0] A_CLAMP = 8'h14;
  localparam logic [7:0] A_TPUT  = 8'h18;
  localparam logic [7:0] A_COEF  = 8'h20;
  localparam logic [7:0] A_OFFS  = 8'h44;
  localparam logic [7:0] A_END   = 8'h50;
  // control fields
  localparam int CTRL_BYP  = 1;
  localparam int CTRL_TPG  = 2;
  localparam int CTRL_MODE = 4;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0076;
  localparam logic [31:0] SIZE_MASK = 32'h1FFF_1FFF;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] SIZE_RST  = 32'h0438_0780;
  localparam int SIZE_H = 16;
  // conversion modes
  localparam logic [2:0] MODE_601  = 3'h0;
  localparam logic [2:0] MODE_709A = 3'h1;
  localparam logic [2:0] MODE_709B = 3'h2;
  localparam logic [2:0] MODE_YUV  = 3'h3;
  localparam logic [2:0] MODE_CUST = 3'h4;
  // frame limits
  localparam logic [12:0] MIN_DIM = 13'h0020;
  localparam logic [12:0] MAX_DIM = 13'h1E00;
  // event bits
  localparam int EV_SOF   = 0;
  localparam int EV_DONE  = 1;
  localparam int EV_SHORT = 2;
  localparam int EV_LONG  = 3;
  localparam int EV_EARLY = 4;
  localparam int EV_STALL = 5;
  localparam logic signed [COEF_W-1:0] ID_COEF = 18'h4000;
  // rows 601, 709, yuv; order y,cb,cr x r,g,b
  localparam logic signed [COEF_W-1:0] COEF_TAB [0:2][0:8] = '{
    '{18'h1323, 18'h2591, 18'h074C, -18'sh0AD1, -18'sh152F, 18'h2000,
      18'h2000, -18'sh1AD1, -18'sh052F},
    '{18'h0D9B, 18'h2DC6, 18'h049F, -18'sh0756, -18'sh18AA, 18'h2000,
      18'h2000, -18'sh1D12, -18'sh02EE},
    '{18'h1323, 18'h2591, 18'h074C, -18'sh0968, -18'sh127F, 18'h1BE7,
      18'h275C, -18'sh20F6, -18'sh0666}};
  typedef struct packed {
    logic                       user;
    logic                       last;
    logic [2:0][CMAX-1:0]       comp;
  } csc_pix_type;
  typedef struct packed {
    logic                       user;
    logic                       last;
    logic signed [2:0][RES_W-1:0] val;
  } csc_res_type;
endpackage : csc_pkg

// File: csc_top.sv
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/100ps
module csc_top #(
  parameter int COMP_W     = 8,
  parameter bit HAS_CLIP   = 1'b1,
  parameter bit HAS_CLAMP  = 1'b1,
  parameter bit HAS_BYPASS = 1'b1,
  parameter bit HAS_TPG    = 1'b1,
  parameter bit HAS_MON    = 1'b1,
  parameter bit HAS_CTRL   = 1'b1,
  parameter bit HAS_INTC   = 1'b1,
  localparam int DATA_W    = ((3*COMP_W+7)/8)*8
) (
  // clock and resets
  input  logic              pclk,
  input  logic              presetn,
  input  logic              core_clken,
  input  logic              core_resetn,
  // apb
  input  logic              psel,
  input  logic              penable,
  input  logic              pwrite,
  input  logic [7:0]        paddr,
  input  logic [31:0]       pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  // rgb in
  input  logic [DATA_W-1:0] s_axis_video_tdata,
  input  logic              s_axis_video_tvalid,
  output logic              s_axis_video_tready,
  input  logic              s_axis_video_tuser,
  input  logic              s_axis_video_tlast,
  // ycc out
  output logic [DATA_W-1:0] m_axis_video_tdata,
  output logic              m_axis_video_tvalid,
  input  logic              m_axis_video_tready,
  output logic              m_axis_video_tuser,
  output logic              m_axis_video_tlast,
  // interrupts
  output logic              irq,
  output logic [5:0]        external_irq_controller_port
);
  localparam int CM  = csc_pkg::CMAX;
  localparam int CW  = csc_pkg::COEF_W;
  localparam int RW  = csc_pkg::RES_W;
  localparam int P_W = CW + CM + 1;
  localparam int A_W = P_W + 2;
  localparam int NR  = csc_pkg::LAT_CORE - 2;

  logic [31:0]          ctrl_q, size_q, mask_q, tput_q, cnt_q;
  logic [5:0]           stat_q, intc_q;
  wire  [5:0]           ev;
  logic [CM-1:0]        clip_q, clamp_q;
  logic signed [CW-1:0] cust_q [0:8];
  logic signed [CM:0]   offs_q [0:2];
  logic [31:0]          prdata_q, rd_d;
  logic                 pslverr_q, err_d, irq_q;
  logic [12:0]          col_q, row_q;
  logic signed [P_W-1:0] prod_q [0:8];
  logic signed [P_W-1:0] prod_d [0:8];
  logic [1:0]           ul_q;
  logic [NR-1:0]        rv_q;
  csc_pkg::csc_res_type res_q [0:NR-1];
  csc_pkg::csc_res_type res_d;
  csc_pkg::csc_pix_type st9_q, sat_d, clip_pix, out_pix;
  logic                 v1_q, v9_q, clip_vld, out_vld;
  logic [DATA_W-1:0]    tdata_w;

  // control decode
  wire          wr_en  = HAS_CTRL & psel & penable & pwrite;
  wire          setup  = psel & ~penable;
  wire [7:0]    ci     = (paddr - csc_pkg::A_COEF) >> 2;
  wire [7:0]    oi     = (paddr - csc_pkg::A_OFFS) >> 2;
  wire          a_al   = paddr[1:0] == 2'h0;
  wire          hit_cf = a_al & paddr >= csc_pkg::A_COEF & paddr < csc_pkg::A_OFFS;
  wire          hit_of = a_al & paddr >= csc_pkg::A_OFFS & paddr < csc_pkg::A_END;
  wire          byp    = HAS_BYPASS & ctrl_q[csc_pkg::CTRL_BYP];
  wire          tpg    = HAS_TPG & ctrl_q[csc_pkg::CTRL_TPG];
  wire [2:0]    mode   = ctrl_q[csc_pkg::CTRL_MODE +: 3];
  wire [CM-1:0] cmask  = {CM{1'b1}} >> (CM - COMP_W);
  wire [12:0]   w_raw  = size_q[12:0];
  wire [12:0]   h_raw  = size_q[csc_pkg::SIZE_H +: 13];
  wire [12:0]   eff_w  = w_raw < csc_pkg::MIN_DIM ? csc_pkg::MIN_DIM :
                         w_raw > csc_pkg::MAX_DIM ? csc_pkg::MAX_DIM : w_raw;
  wire [12:0]   eff_h  = h_raw < csc_pkg::MIN_DIM ? csc_pkg::MIN_DIM :
                         h_raw > csc_pkg::MAX_DIM ? csc_pkg::MAX_DIM : h_raw;

  // stall the whole pipe on enable low or output back-pressure
  wire adv = core_clken & core_resetn & (~out_vld | m_axis_video_tready);
  wire acc = s_axis_video_tvalid & adv;
  wire ot  = out_vld & adv;

  // input unpack, test pattern
  wire [12:0] bc = s_axis_video_tuser ? 13'h0000 : col_q;
  wire [12:0] br = s_axis_video_tuser ? 13'h0000 : row_q;
  logic [CM-1:0] rgb [0:2];
  always_comb begin
    rgb[0] = {{(CM-COMP_W){1'b0}}, s_axis_video_tdata[2*COMP_W +: COMP_W]};
    rgb[1] = {{(CM-COMP_W){1'b0}}, s_axis_video_tdata[0 +: COMP_W]};
    rgb[2] = {{(CM-COMP_W){1'b0}}, s_axis_video_tdata[COMP_W +: COMP_W]};
    if (tpg) begin
      rgb[0] = {3'h0, bc} & cmask;
      rgb[1] = {3'h0, br} & cmask;
      rgb[2] = {3'h0, bc ^ br} & cmask;
    end
  end

  // coefficient and offset selection
  wire [1:0] tab = mode == csc_pkg::MODE_601 ? 2'h0 : mode == csc_pkg::MODE_YUV ? 2'h2 : 2'h1;
  wire       cust = mode == csc_pkg::MODE_CUST;
  wire signed [CM:0] half = 17'h0001 << (COMP_W - 1);
  wire signed [CM:0] y16  = mode == csc_pkg::MODE_709B ? 17'h0010 << (COMP_W - 8) : 17'h0000;
  logic signed [CW-1:0] cf [0:8];
  logic signed [CM:0]   of [0:2];
  always_comb begin
    for (int i = 0; i < 9; i++) begin
      cf[i] = cust ? cust_q[i] : csc_pkg::COEF_TAB[tab][i];
      // bypass routes each input lane straight to the same output lane
      if (byp) cf[i] = (i == 1 || i == 5 || i == 6) ? csc_pkg::ID_COEF : '0;
      prod_d[i] = cf[i] * $signed({1'b0, rgb[i % 3]});
    end
    of[0] = cust ? offs_q[0] : y16;
    of[1] = cust ? offs_q[1] : half;
    of[2] = cust ? offs_q[2] : half;
    if (byp) begin
      of[0] = '0;
      of[1] = '0;
      of[2] = '0;
    end
  end

  logic signed [A_W-1:0] sum [0:2];
  always_comb begin
    res_d = '0;
    res_d.user = ul_q[1];
    res_d.last = ul_q[0];
    for (int r = 0; r < 3; r++) begin
      sum[r] = A_W'(prod_q[3*r]) + A_W'(prod_q[3*r+1]) + A_W'(prod_q[3*r+2])
             + (A_W'(of[r]) <<< csc_pkg::FRAC) + (A_W'(1) <<< (csc_pkg::FRAC - 1));
      res_d.val[r] = RW'(sum[r] >>> csc_pkg::FRAC);
    end
  end

  // saturate to the code range before the last core stage
  always_comb begin
    sat_d = '0;
    sat_d.user = res_q[NR-1].user;
    sat_d.last = res_q[NR-1].last;
    for (int r = 0; r < 3; r++) begin
      if ($signed(res_q[NR-1].val[r]) < 0) sat_d.comp[r] = '0;
      else if ($signed(res_q[NR-1].val[r]) > $signed({1'b0, cmask})) sat_d.comp[r] = cmask;
      else sat_d.comp[r] = res_q[NR-1].val[r][CM-1:0];
    end
  end

  // core pipeline: products, sum, delay, saturate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      v1_q <= 1'b0;
      v9_q <= 1'b0;
      rv_q <= '0;
      ul_q <= 2'h0;
      st9_q <= '0;
      for (int i = 0; i < 9; i++) prod_q[i] <= '0;
      for (int i = 0; i < NR; i++) res_q[i] <= '0;
    end else if (!core_resetn) begin
      v1_q <= 1'b0;
      v9_q <= 1'b0;
      rv_q <= '0;
    end else if (adv) begin
      v1_q <= acc;
      ul_q <= {s_axis_video_tuser, s_axis_video_tlast};
      for (int i = 0; i < 9; i++) prod_q[i] <= prod_d[i];
      rv_q <= {rv_q[NR-2:0], v1_q};
      res_q[0] <= res_d;
      for (int i = 1; i < NR; i++) res_q[i] <= res_q[i-1];
      v9_q <= rv_q[NR-1];
      st9_q <= sat_d;
    end
  end

  generate
    if (HAS_CLIP) begin : g_clip
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          clip_vld <= 1'b0;
          clip_pix <= '0;
        end else if (!core_resetn) begin
          clip_vld <= 1'b0;
        end else if (adv) begin
          clip_vld <= v9_q;
          clip_pix <= st9_q;
          for (int r = 0; r < 3; r++)
            if (st9_q.comp[r] > clip_q) clip_pix.comp[r] <= clip_q;
        end
      end
    end else begin : g_noclip
      assign clip_vld = v9_q;
      assign clip_pix = st9_q;
    end
    if (HAS_CLAMP) begin : g_clamp
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          out_vld <= 1'b0;
          out_pix <= '0;
        end else if (!core_resetn) begin
          out_vld <= 1'b0;
        end else if (adv) begin
          out_vld <= clip_vld;
          out_pix <= clip_pix;
          for (int r = 0; r < 3; r++)
            if (clip_pix.comp[r] < clamp_q) out_pix.comp[r] <= clamp_q;
        end
      end
    end else begin : g_noclamp
      assign out_vld = clip_vld;
      assign out_pix = clip_pix;
    end
  endgenerate

  always_comb begin
    tdata_w = '0;
    for (int r = 0; r < 3; r++) tdata_w[r*COMP_W +: COMP_W] = out_pix.comp[r][COMP_W-1:0];
  end
  assign m_axis_video_tdata  = tdata_w;
  assign m_axis_video_tvalid = out_vld;
  assign m_axis_video_tuser  = out_pix.user;
  assign m_axis_video_tlast  = out_pix.last;
  assign s_axis_video_tready = adv;

  // frame checking and output stall events
  wire [12:0] cn = bc + 13'h0001;
  wire        lc = cn == eff_w;
  assign ev[csc_pkg::EV_SOF]   = acc & s_axis_video_tuser;
  assign ev[csc_pkg::EV_EARLY] = acc & s_axis_video_tuser & (col_q != 13'h0000 | row_q != 13'h0000);
  assign ev[csc_pkg::EV_SHORT] = acc & s_axis_video_tlast & ~lc;
  assign ev[csc_pkg::EV_LONG]  = acc & ~s_axis_video_tlast & lc;
  assign ev[csc_pkg::EV_DONE]  = acc & s_axis_video_tlast & (br + 13'h0001 == eff_h);
  assign ev[csc_pkg::EV_STALL] = core_clken & core_resetn & out_vld & ~m_axis_video_tready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col_q <= '0;
      row_q <= '0;
      cnt_q <= '0;
      tput_q <= '0;
    end else if (!core_resetn) begin
      col_q <= '0;
      row_q <= '0;
      cnt_q <= '0;
    end else begin
      if (acc) begin
        col_q <= s_axis_video_tlast ? 13'h0000 : cn;
        if (s_axis_video_tlast) row_q <= (br + 13'h0001 == eff_h) ? 13'h0000 : br + 13'h0001;
        else row_q <= br;
      end
      if (HAS_MON && ot) begin
        cnt_q <= out_pix.user ? 32'h0000_0001 : cnt_q + 32'h0000_0001;
        if (out_pix.user) tput_q <= cnt_q;
      end
    end
  end

  // register read mux
  always_comb begin
    rd_d = '0;
    err_d = 1'b0;
    if (paddr == csc_pkg::A_CTRL) rd_d = ctrl_q;
    else if (paddr == csc_pkg::A_STAT) rd_d = {26'h0, stat_q};
    else if (paddr == csc_pkg::A_MASK) rd_d = mask_q;
    else if (paddr == csc_pkg::A_SIZE) rd_d = size_q;
    else if (paddr == csc_pkg::A_CLIP) rd_d = {16'h0000, clip_q};
    else if (paddr == csc_pkg::A_CLAMP) rd_d = {16'h0000, clamp_q};
    else if (paddr == csc_pkg::A_TPUT) rd_d = tput_q;
    else if (hit_cf) rd_d = 32'(cust_q[ci[3:0]]);
    else if (hit_of) rd_d = 32'(offs_q[oi[1:0]]);
    else err_d = 1'b1;
  end

  // register file, apb answer, interrupts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= csc_pkg::CTRL_RST;
      size_q <= csc_pkg::SIZE_RST;
      mask_q <= '0;
      stat_q <= '0;
      clip_q <= {CM{1'b1}};
      clamp_q <= '0;
      for (int i = 0; i < 9; i++) cust_q[i] <= (i % 4 == 0) ? csc_pkg::ID_COEF : '0;
      for (int i = 0; i < 3; i++) offs_q[i] <= '0;
      prdata_q <= '0;
      pslverr_q <= 1'b0;
      irq_q <= 1'b0;
      intc_q <= '0;
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        prdata_q <= HAS_CTRL ? rd_d : 32'h0000_0000;
        pslverr_q <= HAS_CTRL & err_d;
      end
      if (wr_en && paddr == csc_pkg::A_CTRL) ctrl_q <= pwdata & csc_pkg::CTRL_MASK;
      if (wr_en && paddr == csc_pkg::A_MASK) mask_q <= {26'h0, pwdata[5:0]};
      if (wr_en && paddr == csc_pkg::A_SIZE) size_q <= pwdata & csc_pkg::SIZE_MASK;
      if (wr_en && paddr == csc_pkg::A_CLIP) clip_q <= pwdata[CM-1:0];
      if (wr_en && paddr == csc_pkg::A_CLAMP) clamp_q <= pwdata[CM-1:0];
      if (wr_en && hit_cf) cust_q[ci[3:0]] <= pwdata[CW-1:0];
      if (wr_en && hit_of) offs_q[oi[1:0]] <= pwdata[CM:0];
      // set wins over write-one-to-clear
      stat_q <= (stat_q & ~((wr_en && paddr == csc_pkg::A_STAT) ? pwdata[5:0] : 6'h00)) | ev;
      irq_q <= HAS_CTRL & |(stat_q & mask_q[5:0]);
      intc_q <= HAS_INTC ? ev : 6'h00;
    end
  end
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;
  assign irq     = irq_q;
  assign external_irq_controller_port = intc_q;
endmodule : csc_top

// File: csc_asserts.sv
`timescale 1ns/100ps
module csc_asserts #(
  parameter int COMP_W = 8,
  localparam int DW    = ((3*COMP_W+7)/8)*8
) (
  // clock and resets
  input logic          pclk,
  input logic          presetn,
  input logic          core_clken,
  input logic          core_resetn,
  // apb
  input logic          psel,
  input logic          penable,
  input logic [7:0]    paddr,
  input logic          pready,
  input logic          pslverr,
  // streams
  input logic          s_axis_video_tvalid,
  input logic          s_axis_video_tready,
  input logic          s_axis_video_tuser,
  input logic          s_axis_video_tlast,
  input logic [DW-1:0] m_axis_video_tdata,
  input logic          m_axis_video_tvalid,
  input logic          m_axis_video_tready,
  input logic          m_axis_video_tuser,
  input logic          m_axis_video_tlast,
  // events
  input logic [5:0]    external_irq_controller_port
);
  wire take = s_axis_video_tvalid & s_axis_video_tready;
  wire go   = core_clken & core_resetn & m_axis_video_tready;
  wire hold = m_axis_video_tvalid & ~m_axis_video_tready;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ten advancing edges after a take, output stands at the eleventh
  sequence run_s;
    go [*8] ##1 go [*2];
  endsequence
  lat_valid_a: assert property (take ##1 run_s |=> m_axis_video_tvalid)
    else $error("output valid late");
  lat_user_a: assert property (take && s_axis_video_tuser ##1 run_s |=> m_axis_video_tuser)
    else $error("frame start lost");
  lat_last_a: assert property (take && s_axis_video_tlast ##1 run_s |=> m_axis_video_tlast)
    else $error("line end lost");
  in_ready_a: assert property (s_axis_video_tready == (go | core_clken & core_resetn &
    ~m_axis_video_tvalid)) else $error("input ready wrong");
  clken_hold_a: assert property (!core_clken && core_resetn |=>
    $stable(m_axis_video_tvalid) && $stable(m_axis_video_tdata)) else $error("moved while off");
  stall_hold_a: assert property (hold && core_resetn |=>
    $stable({m_axis_video_tvalid, m_axis_video_tdata, m_axis_video_tuser, m_axis_video_tlast}))
    else $error("output dropped under stall");
  core_flush_a: assert property (!core_resetn |-> !s_axis_video_tready ##1
    !m_axis_video_tvalid) else $error("core reset ignored");
  stall_event_a: assert property (hold && core_clken && core_resetn |->
    ##[1:2] external_irq_controller_port[5]) else $error("stall event missing");
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("apb wait state");
  apb_err_a: assert property (psel && !penable && paddr >= 8'h50 |=> pslverr)
    else $error("unmapped not refused");
endmodule : csc_asserts
bind csc_top csc_asserts #(.COMP_W(COMP_W)) csc_asserts_inst (
  .pclk(pclk), .presetn(presetn), .core_clken(core_clken), .core_resetn(core_resetn),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .s_axis_video_tvalid(s_axis_video_tvalid), .s_axis_video_tready(s_axis_video_tready),
  .s_axis_video_tuser(s_axis_video_tuser), .s_axis_video_tlast(s_axis_video_tlast),
  .m_axis_video_tdata(m_axis_video_tdata), .m_axis_video_tvalid(m_axis_video_tvalid),
  .m_axis_video_tready(m_axis_video_tready), .m_axis_video_tuser(m_axis_video_tuser),
  .m_axis_video_tlast(m_axis_video_tlast),
  .external_irq_controller_port(external_irq_controller_port));

// File: csc_sink.sv
`timescale 1ns/100ps
module csc_sink (
  // clock and reset
  input logic  pclk,
  input logic  presetn,
  // stream
  input logic  stall,
  output logic m_tready
);
  logic [1:0] cnt_q;
  // ready changes only after an edge; half the time low when stalling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q    <= 2'h0;
      m_tready <= 1'b0;
    end else begin
      cnt_q    <= cnt_q + 2'h1;
      m_tready <= !stall || cnt_q[1];
    end
  end
endmodule : csc_sink

// File: csc_tb.sv
`timescale 1ns/100ps
module testbench;
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  clip;
    logic [7:0]  clamp;
    logic [23:0] din;
    logic [23:0] dout;
  } csc_row_type;
  logic        pclk, presetn, core_clken, core_resetn, stall, err;
  logic        psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] s_data, m_data, px;
  logic        s_valid, s_ready, s_user, s_last, m_valid, m_ready, m_user, m_last;
  logic [5:0]  ext_irq;
  logic [25:0] exp_q [$];
  int          num_errors, comparisons, n, waits;
  csc_row_type rows [0:9] = '{
    '{8'h00, 8'hFF, 8'h00, 24'h50_5050, 24'h80_8050},
    '{8'h10, 8'hFF, 8'h00, 24'h50_5050, 24'h80_8050},
    '{8'h20, 8'hFF, 8'h00, 24'h50_5050, 24'h80_8060},
    '{8'h20, 8'hFF, 8'h00, 24'hF8_F8F8, 24'h80_80FF},
    '{8'h30, 8'hFF, 8'h00, 24'h50_5050, 24'h80_8050},
    '{8'h40, 8'hFF, 8'h00, 24'h11_3322, 24'h33_2211},
    '{8'h02, 8'hFF, 8'h00, 24'hA1_B2C3, 24'hA1_B2C3},
    '{8'h00, 8'h60, 8'h00, 24'h70_7070, 24'h60_6060},
    '{8'h00, 8'hFF, 8'h90, 24'h20_2020, 24'h90_9090},
    '{8'h50, 8'hFF, 8'h00, 24'h50_5050, 24'h80_8050}};
  csc_top csc_top_inst (
    .pclk(pclk), .presetn(presetn), .core_clken(core_clken), .core_resetn(core_resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .s_axis_video_tdata(s_data), .s_axis_video_tvalid(s_valid),
    .s_axis_video_tready(s_ready), .s_axis_video_tuser(s_user), .s_axis_video_tlast(s_last),
    .m_axis_video_tdata(m_data), .m_axis_video_tvalid(m_valid),
    .m_axis_video_tready(m_ready), .m_axis_video_tuser(m_user), .m_axis_video_tlast(m_last),
    .irq(irq), .external_irq_controller_port(ext_irq));
  csc_sink csc_sink_inst (.pclk(pclk), .presetn(presetn), .stall(stall), .m_tready(m_ready));
  initial pclk = 1'b0;
  always #50 pclk = ~pclk;
  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic close_out();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (!pready && k < 50);
    if (k == 50) chk("pready", 1, 0);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask : apb
  task automatic send(input logic [23:0] d, e, input logic u, l, more);
    int k;
    exp_q.push_back({u, l, e});
    {s_valid, s_data, s_user, s_last} <= {1'b1, d, u, l};
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (!s_ready && k < 200);
    if (k == 200) chk("s_ready", 1, 0);
    waits += k;
    if (!more) s_valid <= 1'b0;
  endtask : send
  task automatic drain();
    int k;
    k = 0;
    while (exp_q.size() != 0 && k < 300) begin
      @(posedge pclk);
      k++;
    end
    if (k == 300) chk("drain", 0, 1);
    @(posedge pclk);
  endtask : drain
  always @(posedge pclk) begin
    if (m_valid && m_ready && core_clken && core_resetn && presetn) begin
      if (exp_q.size() == 0) chk("extra output", 0, 1);
      else chk("output", 32'(exp_q.pop_front()), 32'({m_user, m_last, m_data}));
    end
  end
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    close_out();
  end
  initial begin
    {presetn, core_resetn, psel, penable, pwrite, s_valid, s_user, s_last, stall} = '0;
    {core_clken, paddr, pwdata, s_data, num_errors, comparisons} = '0;
    core_clken = 1'b1;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h0C, 32'h0);
    chk("size reset", 32'h0438_0780, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("clip reset", 32'h0000_FFFF, rd);
    apb(1'b0, 8'h20, 32'h0);
    chk("coef reset", 32'h0000_4000, rd);
    apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    apb(1'b0, 8'h0C, 32'h0);
    chk("size write", 32'h1FFF_1FFF, rd);
    apb(1'b0, 8'h50, 32'h0);
    chk("unmapped", 32'h0000_0001, {rd[30:0], err});
    repeat (32) @(posedge pclk);
    core_resetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 10; i++) begin
      apb(1'b1, 8'h00, 32'(rows[i].ctrl));
      apb(1'b1, 8'h10, 32'(rows[i].clip));
      apb(1'b1, 8'h14, 32'(rows[i].clamp));
      send(rows[i].din, rows[i].dout, i[0], i[1], 1'b0);
      drain();
      $display("row %0d done", i);
    end
    apb(1'b1, 8'h00, 32'h0000_0002);
    send(24'h12_3456, 24'h12_3456, 1'b0, 1'b0, 1'b0);
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (!m_valid && n < 40);
    chk("latency", csc_pkg::LAT_CORE + 2, 32'(n + 1));
    drain();
    waits = 0;
    for (int i = 0; i < 8; i++) send(24'(i), 24'(i), 1'b0, i == 7, i < 7);
    chk("throughput", 8, 32'(waits));
    drain();
    $display("latency and rate done");
    stall <= 1'b1;
    fork
      for (int i = 0; i < 16; i++) begin
        px = {i[7:0], ~i[7:0], i[7:0] ^ 8'h5A};
        send(px, px, i == 0, i == 15, i < 15);
      end
      begin
        repeat (6) @(posedge pclk);
        core_clken <= 1'b0;
        repeat (4) @(posedge pclk);
        core_clken <= 1'b1;
      end
    join
    drain();
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk("frame count", 32'h0000_000A, rd);
    stall <= 1'b0;
    send(24'h00_0001, 24'h00_0001, 1'b0, 1'b0, 1'b0);
    @(posedge pclk);
    core_resetn <= 1'b0;
    exp_q.delete();
    repeat (32) @(posedge pclk);
    chk("flush", 0, 32'({m_valid, s_ready}));
    core_resetn <= 1'b1;
    repeat (15) @(posedge pclk);
    $display("stall and reset done");
    apb(1'b1, 8'h08, 32'h0);
    apb(1'b1, 8'h04, 32'h0000_003F);
    send(24'h00_0000, 24'h00_0000, 1'b1, 1'b0, 1'b0);
    drain();
    chk("irq masked", 0, 32'(irq));
    apb(1'b1, 8'h08, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk("irq set", 1, 32'(irq));
    apb(1'b0, 8'h04, 32'h0);
    chk("sof status", 1, rd & 32'h0000_0001);
    apb(1'b1, 8'h04, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 0, 32'(irq));
    $display("irq done");
    apb(1'b1, 8'h00, 32'h0000_0004);
    send(24'hFF_FFFF, 24'h80_8000, 1'b1, 1'b0, 1'b0);
    drain();
    apb(1'b1, 8'h44, 32'h0001_FF00);
    apb(1'b1, 8'h00, 32'h0000_0040);
    send(24'h10_2030, 24'h20_3000, 1'b0, 1'b0, 1'b0);
    drain();
    $display("pattern and floor done");
    close_out();
  end
endmodule : testbench
